// ==== tm2_pkg.sv ====
// Shared constants for the timer 2 compare-B, interrupt and asynchronous status block.
package tm2_pkg;

    localparam logic [7:0] ADDR_FLAGS      = 8'h37;
    localparam logic [7:0] ADDR_SYNC_CTRL  = 8'h43;
    localparam logic [7:0] ADDR_MASK       = 8'h70;
    localparam logic [7:0] ADDR_CTRL_A     = 8'hB0;
    localparam logic [7:0] ADDR_CTRL_B     = 8'hB1;
    localparam logic [7:0] ADDR_COUNTER    = 8'hB2;
    localparam logic [7:0] ADDR_CMP_A      = 8'hB3;
    localparam logic [7:0] ADDR_CMP_B      = 8'hB4;
    localparam logic [7:0] ADDR_ASYNC_STAT = 8'hB6;
    localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
    localparam logic [7:0] EXT_IO_BASE     = 8'h60;

    localparam int BIT_CMP_B     = 2;
    localparam int BIT_CMP_A     = 1;
    localparam int BIT_OVF       = 0;
    localparam int BIT_EXT_CLK   = 6;
    localparam int BIT_ASYNC_SEL = 5;
    localparam int BIT_HOLD_MODE = 7;
    localparam int BIT_SYNC_RST  = 0;
    localparam int BIT_ASYNC_RST = 1;

    localparam logic [2:0] IRQ_FIELD_MASK  = 3'h7;
    localparam logic [7:0] RESET_VALUE     = 8'h00;
    localparam logic [7:0] BOTTOM_VALUE    = 8'h00;
    localparam logic [7:0] MAX_VALUE       = 8'hFF;
    localparam logic [2:0] MODE_PC_PWM     = 3'h1;
    localparam logic [2:0] MODE_PC_PWM_OCA = 3'h5;
    localparam logic [2:0] MODE_CTC        = 3'h2;
    localparam logic [2:0] MODE_FAST_OCA   = 3'h7;

    // Register write targets that carry an update-busy bit, in status bit order 0..4.
    typedef enum logic [2:0] {
        TM2_UPD_CTRL_B,
        TM2_UPD_CTRL_A,
        TM2_UPD_CMP_B,
        TM2_UPD_CMP_A,
        TM2_UPD_COUNTER
    } tm2_upd_t;

    localparam int NUM_UPD = 5;

endpackage : tm2_pkg

// ==== tm2_irq_async.sv ====
// Timer 2 compare-B, interrupt mask and flags, asynchronous status and prescaler sync control.
`timescale 1ns/1ns
`default_nettype none

module tm2_irq_async #(
    parameter int XFER_CYCLES = 4
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic       i_io_space,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_global_irq_en,
    input  wire logic [2:0] i_irq_ack,
    input  wire logic       i_async_tick,
    output logic      [7:0] o_rdata,
    output logic      [2:0] o_irq_req,
    output logic            o_waveform_out_b,
    output logic            o_ext_clock_buf_en,
    output logic            o_crystal_osc_en,
    output logic            o_async_clock_sel,
    output logic            o_sync_prescaler_rst,
    output logic            o_async_prescaler_rst,
    output logic      [7:0] o_counter_value
);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [7:0] rdata;
        logic [2:0] irq_req;
        logic [2:0] mask;
        logic [2:0] flags;
        logic [7:0] counter_value;
        logic [7:0] compare_a_value;
        logic [7:0] compare_b_value;
        logic [7:0] ctrl_a_reg;
        logic [7:0] ctrl_b_reg;
        logic [7:0] pend_counter;
        logic [7:0] pend_cmp_a;
        logic [7:0] pend_cmp_b;
        logic [7:0] pend_ctrl_a;
        logic [7:0] pend_ctrl_b;
        logic [4:0] upd_busy;
        logic [3:0] xfer_cnt;
        logic       ext_clock_in_en;
        logic       async_clock_sel;
        logic       sync_hold_mode;
        logic       sync_prescaler_rst;
        logic       async_prescaler_rst;
        logic       count_down;
        logic [9:0] prescale;
        logic       waveform_out_b;
        logic       ext_buf_en;
        logic       osc_en;
    } tm2_state_t;

    tm2_state_t s_q;
    tm2_state_t s_d;

    logic [7:0] eff_addr;
    logic       addr_ok;
    logic       tick;
    logic [2:0] mode;
    logic [7:0] top;
    logic [2:0] events;
    logic       wr_async;

    ////////////////////////////////////////////////////////////////////////////////
    // Combinational next state.

    always_comb begin
        s_d      = s_q;
        events   = 3'h0;
        // I/O instructions reach only the low region, shifted by 0x20.
        eff_addr = i_io_space ? 8'(i_addr + tm2_pkg::IO_SPACE_OFFSET) : i_addr;
        addr_ok  = !(i_io_space && (eff_addr >= tm2_pkg::EXT_IO_BASE));
        mode     = {s_q.ctrl_b_reg[3], s_q.ctrl_a_reg[1:0]};
        top      = (mode == tm2_pkg::MODE_PC_PWM_OCA || mode == tm2_pkg::MODE_CTC ||
                    mode == tm2_pkg::MODE_FAST_OCA) ? s_q.compare_a_value : tm2_pkg::MAX_VALUE;
        wr_async = i_wr && addr_ok && s_q.async_clock_sel;

        // Counter clock: I/O clock prescaled, or the asynchronous tick.
        s_d.prescale = 10'(s_q.prescale + 10'h001);
        if (s_q.sync_prescaler_rst) begin
            s_d.prescale = 10'h000;
        end
        if (s_q.async_clock_sel) begin
            tick = i_async_tick && !s_q.async_prescaler_rst;
        end else begin
            case (s_q.ctrl_b_reg[2:0])
                3'h0:    tick = 1'b0;
                3'h1:    tick = 1'b1;
                3'h2:    tick = s_q.prescale[2:0] == 3'h7;
                3'h3:    tick = s_q.prescale[4:0] == 5'h1F;
                3'h4:    tick = s_q.prescale[5:0] == 6'h3F;
                3'h5:    tick = s_q.prescale[6:0] == 7'h7F;
                3'h6:    tick = s_q.prescale[7:0] == 8'hFF;
                default: tick = s_q.prescale == 10'h3FF;
            endcase
            tick = tick && !s_q.sync_prescaler_rst;
        end

        if (tick) begin
            if (mode == tm2_pkg::MODE_PC_PWM || mode == tm2_pkg::MODE_PC_PWM_OCA) begin
                if (s_q.count_down) begin
                    s_d.counter_value = 8'(s_q.counter_value - 8'h01);
                    if (s_q.counter_value == 8'h01) begin
                        s_d.count_down = 1'b0;
                    end
                end else begin
                    s_d.counter_value = 8'(s_q.counter_value + 8'h01);
                    if (8'(s_q.counter_value + 8'h01) == top) begin
                        s_d.count_down = 1'b1;
                    end
                end
                // Overflow marks the turn at bottom in up-down PWM.
                events[tm2_pkg::BIT_OVF] = s_q.count_down &&
                                           s_q.counter_value == 8'(tm2_pkg::BOTTOM_VALUE + 8'h01);
            end else begin
                s_d.counter_value = (s_q.counter_value == top) ? tm2_pkg::BOTTOM_VALUE
                                                               : 8'(s_q.counter_value + 8'h01);
                events[tm2_pkg::BIT_OVF] = s_q.counter_value == tm2_pkg::MAX_VALUE;
            end
            events[tm2_pkg::BIT_CMP_A] = s_q.counter_value == s_q.compare_a_value;
            events[tm2_pkg::BIT_CMP_B] = s_q.counter_value == s_q.compare_b_value;
            if (events[tm2_pkg::BIT_CMP_B]) begin
                s_d.waveform_out_b = !s_q.waveform_out_b;
            end
        end

        // Pending asynchronous writes transfer after the link settles.
        if (s_q.upd_busy != 5'h00 && i_async_tick) begin
            if (s_q.xfer_cnt == 4'(XFER_CYCLES - 1)) begin
                s_d.xfer_cnt = 4'h0;
                s_d.upd_busy = 5'h00;
                if (s_q.upd_busy[tm2_pkg::TM2_UPD_COUNTER])
                    s_d.counter_value = s_q.pend_counter;
                if (s_q.upd_busy[tm2_pkg::TM2_UPD_CMP_A])
                    s_d.compare_a_value = s_q.pend_cmp_a;
                if (s_q.upd_busy[tm2_pkg::TM2_UPD_CMP_B])
                    s_d.compare_b_value = s_q.pend_cmp_b;
                if (s_q.upd_busy[tm2_pkg::TM2_UPD_CTRL_A])
                    s_d.ctrl_a_reg = s_q.pend_ctrl_a;
                if (s_q.upd_busy[tm2_pkg::TM2_UPD_CTRL_B])
                    s_d.ctrl_b_reg = s_q.pend_ctrl_b;
            end else begin
                s_d.xfer_cnt = 4'(s_q.xfer_cnt + 4'h1);
            end
        end

        // Flags: vector ack or written one clears, zero leaves, events win.
        s_d.flags = s_q.flags & ~i_irq_ack;
        if (i_wr && addr_ok && eff_addr == tm2_pkg::ADDR_FLAGS) begin
            s_d.flags = s_d.flags & ~i_wdata[2:0];
        end
        s_d.flags = s_d.flags | events;

        // Self-clearing sync reset unless hold mode keeps it.
        if (!s_q.sync_hold_mode) begin
            s_d.sync_prescaler_rst  = 1'b0;
            s_d.async_prescaler_rst = 1'b0;
        end

        // Register writes. A write during busy is not refused; hardware cannot protect it.
        if (i_wr && addr_ok) begin
            if (eff_addr == tm2_pkg::ADDR_MASK) begin
                s_d.mask = i_wdata[2:0] & tm2_pkg::IRQ_FIELD_MASK;
            end else if (eff_addr == tm2_pkg::ADDR_CMP_B) begin
                if (wr_async) begin
                    s_d.pend_cmp_b = i_wdata;
                    s_d.upd_busy[tm2_pkg::TM2_UPD_CMP_B] = 1'b1;
                end else begin
                    s_d.compare_b_value = i_wdata;
                end
            end else if (eff_addr == tm2_pkg::ADDR_CMP_A) begin
                if (wr_async) begin
                    s_d.pend_cmp_a = i_wdata;
                    s_d.upd_busy[tm2_pkg::TM2_UPD_CMP_A] = 1'b1;
                end else begin
                    s_d.compare_a_value = i_wdata;
                end
            end else if (eff_addr == tm2_pkg::ADDR_COUNTER) begin
                if (wr_async) begin
                    s_d.pend_counter = i_wdata;
                    s_d.upd_busy[tm2_pkg::TM2_UPD_COUNTER] = 1'b1;
                end else begin
                    s_d.counter_value = i_wdata;
                end
            end else if (eff_addr == tm2_pkg::ADDR_CTRL_A) begin
                if (wr_async) begin
                    s_d.pend_ctrl_a = i_wdata;
                    s_d.upd_busy[tm2_pkg::TM2_UPD_CTRL_A] = 1'b1;
                end else begin
                    s_d.ctrl_a_reg = i_wdata;
                end
            end else if (eff_addr == tm2_pkg::ADDR_CTRL_B) begin
                if (wr_async) begin
                    s_d.pend_ctrl_b = i_wdata & 8'h3F;
                    s_d.upd_busy[tm2_pkg::TM2_UPD_CTRL_B] = 1'b1;
                end else begin
                    s_d.ctrl_b_reg = i_wdata & 8'h3F;
                end
            end else if (eff_addr == tm2_pkg::ADDR_ASYNC_STAT) begin
                s_d.ext_clock_in_en = i_wdata[tm2_pkg::BIT_EXT_CLK];
                s_d.async_clock_sel = i_wdata[tm2_pkg::BIT_ASYNC_SEL];
            end else if (eff_addr == tm2_pkg::ADDR_SYNC_CTRL) begin
                s_d.sync_hold_mode = i_wdata[tm2_pkg::BIT_HOLD_MODE];
                if (i_wdata[tm2_pkg::BIT_HOLD_MODE]) begin
                    s_d.sync_prescaler_rst  = i_wdata[tm2_pkg::BIT_SYNC_RST];
                    s_d.async_prescaler_rst = i_wdata[tm2_pkg::BIT_ASYNC_RST];
                end else begin
                    // Reset still acts for this one cycle, then both start together.
                    s_d.sync_prescaler_rst  = i_wdata[tm2_pkg::BIT_SYNC_RST];
                    s_d.async_prescaler_rst = i_wdata[tm2_pkg::BIT_ASYNC_RST];
                end
            end
        end

        // Clock pin buffer and crystal oscillator enables.
        s_d.ext_buf_en = s_d.ext_clock_in_en && s_d.async_clock_sel;
        s_d.osc_en     = s_d.async_clock_sel && !s_d.ext_clock_in_en;

        // Request needs mask, global enable and flag together.
        s_d.irq_req = s_d.flags & s_d.mask & {3{i_global_irq_en}};

        // Read data is registered, so it appears the cycle after the strobe.
        s_d.rdata = 8'h00;
        if (i_rd && addr_ok) begin
            if (eff_addr == tm2_pkg::ADDR_FLAGS) begin
                s_d.rdata = {5'h00, s_q.flags};
            end else if (eff_addr == tm2_pkg::ADDR_MASK) begin
                s_d.rdata = {5'h00, s_q.mask};
            end else if (eff_addr == tm2_pkg::ADDR_CMP_B) begin
                s_d.rdata = s_q.compare_b_value;
            end else if (eff_addr == tm2_pkg::ADDR_CMP_A) begin
                s_d.rdata = s_q.compare_a_value;
            end else if (eff_addr == tm2_pkg::ADDR_COUNTER) begin
                s_d.rdata = s_q.counter_value;
            end else if (eff_addr == tm2_pkg::ADDR_CTRL_A) begin
                s_d.rdata = s_q.ctrl_a_reg;
            end else if (eff_addr == tm2_pkg::ADDR_CTRL_B) begin
                s_d.rdata = s_q.ctrl_b_reg;
            end else if (eff_addr == tm2_pkg::ADDR_ASYNC_STAT) begin
                s_d.rdata = {1'b0, s_q.ext_clock_in_en, s_q.async_clock_sel, s_q.upd_busy};
            end else if (eff_addr == tm2_pkg::ADDR_SYNC_CTRL) begin
                s_d.rdata = {s_q.sync_hold_mode, 6'h00, s_q.sync_prescaler_rst};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata               = s_q.rdata;
    assign o_irq_req             = s_q.irq_req;
    assign o_waveform_out_b      = s_q.waveform_out_b;
    assign o_ext_clock_buf_en    = s_q.ext_buf_en;
    assign o_crystal_osc_en      = s_q.osc_en;
    assign o_async_clock_sel     = s_q.async_clock_sel;
    assign o_sync_prescaler_rst  = s_q.sync_prescaler_rst;
    assign o_async_prescaler_rst = s_q.async_prescaler_rst;
    assign o_counter_value       = s_q.counter_value;

endmodule : tm2_irq_async

`default_nettype wire

// ==== tm2_irq_async_properties.sv ====
// Port-level checks for the timer 2 interrupt, async status and prescaler sync block.
`timescale 1ns/1ns
`default_nettype none
module tm2_irq_async_properties #(
    parameter int XFER_CYCLES = 4
) (
    input wire logic       i_sys_clk,
    input wire logic       i_rst,
    input wire logic [7:0] i_addr,
    input wire logic       i_io_space,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] i_wdata,
    input wire logic       i_global_irq_en,
    input wire logic [7:0] o_rdata,
    input wire logic [2:0] o_irq_req,
    input wire logic       o_ext_clock_buf_en,
    input wire logic       o_crystal_osc_en,
    input wire logic       o_async_clock_sel,
    input wire logic       o_sync_prescaler_rst,
    input wire logic       o_async_prescaler_rst
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic wr_stat;
    logic wr_sync;
    assign wr_stat = i_wr && !i_io_space && i_addr == 8'hB6;
    assign wr_sync = i_wr && !i_io_space && i_addr == 8'h43;
    ////////////////////////////////////////////////////////////////////////////////
    irq_gate_off_a: assert property (!i_global_irq_en [*2] |-> o_irq_req == 3'h0)
        else $error("interrupt request while globally disabled");
    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside its slot");
    io_high_read_a: assert property (i_rd && i_io_space && i_addr >= 8'h40 |=> o_rdata == 8'h00)
        else $error("io access reached extended space");
    buf_excl_a: assert property (o_ext_clock_buf_en |-> o_async_clock_sel && !o_crystal_osc_en)
        else $error("external buffer enabled wrongly");
    xtal_sel_a: assert property (o_crystal_osc_en |-> o_async_clock_sel)
        else $error("crystal running without async select");
    // Back-to-back writes are legal, so each check looks only where no later write can reach.
    sel_follow_a: assert property (wr_stat |=> o_async_clock_sel == $past(i_wdata[5]))
        else $error("async select not following write");
    xtal_follow_a: assert property (wr_stat |=>
        o_crystal_osc_en == ($past(i_wdata[5]) && !$past(i_wdata[6])))
        else $error("crystal enable not following write");
    sync_self_clr_a: assert property (wr_sync && i_wdata == 8'h01 |=>
        o_sync_prescaler_rst ##1 ($past(wr_sync) || !o_sync_prescaler_rst))
        else $error("sync prescaler reset did not self-clear");
    hold_keeps_a: assert property (wr_sync && i_wdata == 8'h83 |=>
        (o_sync_prescaler_rst && o_async_prescaler_rst) ##1
        ($past(wr_sync) || (o_sync_prescaler_rst && o_async_prescaler_rst)))
        else $error("prescaler resets not held");
    hold_release_a: assert property (wr_sync && i_wdata == 8'h00 |=>
        !o_sync_prescaler_rst && !o_async_prescaler_rst)
        else $error("prescaler resets not released");
    cover property (o_irq_req == 3'h7);
    cover property (o_ext_clock_buf_en);
    cover property (o_sync_prescaler_rst && o_async_prescaler_rst);
endmodule : tm2_irq_async_properties
bind tm2_irq_async tm2_irq_async_properties #(.XFER_CYCLES(XFER_CYCLES)) u_props (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_io_space(i_io_space),
    .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_global_irq_en(i_global_irq_en),
    .o_rdata(o_rdata), .o_irq_req(o_irq_req), .o_ext_clock_buf_en(o_ext_clock_buf_en),
    .o_crystal_osc_en(o_crystal_osc_en), .o_async_clock_sel(o_async_clock_sel),
    .o_sync_prescaler_rst(o_sync_prescaler_rst), .o_async_prescaler_rst(o_async_prescaler_rst));
`default_nettype wire

// ==== tm2_irq_async_tb.sv ====
// Self-checking bench for the timer 2 interrupt, async status and prescaler sync block.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tm2_irq_async_tb;
    localparam int XC = 4;
    logic       i_sys_clk, i_rst, i_io_space, i_wr, i_rd, i_global_irq_en, i_async_tick;
    logic [7:0] i_addr, i_wdata, o_rdata, o_counter_value;
    logic [2:0] i_irq_ack, o_irq_req;
    logic       o_wave, o_buf, o_xtal, o_sel, o_srst, o_arst;
    int         bad_count = 0;
    int         n_compared = 0;
    tm2_irq_async #(.XFER_CYCLES(XC)) dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_io_space(i_io_space),
        .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .i_global_irq_en(i_global_irq_en),
        .i_irq_ack(i_irq_ack), .i_async_tick(i_async_tick), .o_rdata(o_rdata),
        .o_irq_req(o_irq_req), .o_waveform_out_b(o_wave), .o_ext_clock_buf_en(o_buf),
        .o_crystal_osc_en(o_xtal), .o_async_clock_sel(o_sel),
        .o_sync_prescaler_rst(o_srst), .o_async_prescaler_rst(o_arst),
        .o_counter_value(o_counter_value));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : cyc
    // Strobes stand exactly one sampled edge, then a free cycle follows before the next.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic io = 1'b0);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_io_space <= io;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] ex,
                       input logic io = 1'b0);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_io_space <= io;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(nm, ex, o_rdata)
    endtask : rdc
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rdc("mask rst", 8'h70, 8'h00);
        rdc("cmpb rst", 8'hB4, 8'h00);
        rdc("stat rst", 8'hB6, 8'h00);
        rdc("unmapped", 8'hC0, 8'h00);
        wr(8'h70, 8'hFF);
        rdc("mask", 8'h70, 8'h07);
        rdc("mask via io", 8'h50, 8'h00, 1'b1);
    endtask : t_regs
    task automatic t_flags;
        wr(8'hB3, 8'h80);
        wr(8'hB4, 8'h40);
        wr(8'hB1, 8'h01);
        cyc(300);
        wr(8'hB1, 8'h00);
        wr(8'hB2, 8'h10);
        `CHK("wave b", 1'b1, o_wave)
        `CHK("counter wr", 8'h10, o_counter_value)
        rdc("flags", 8'h37, 8'h07);
        rdc("flags io", 8'h17, 8'h07, 1'b1);
        @(posedge i_sys_clk);
        i_global_irq_en <= 1'b1;
        cyc(3);
        `CHK("irq on", 3'h7, o_irq_req)
        @(posedge i_sys_clk);
        i_global_irq_en <= 1'b0;
        cyc(3);
        `CHK("irq off", 3'h0, o_irq_req)
        wr(8'h37, 8'h00);
        rdc("zero keeps", 8'h37, 8'h07);
        wr(8'h37, 8'h04);
        rdc("one clears", 8'h37, 8'h03);
        @(posedge i_sys_clk);
        i_irq_ack <= 3'h2;
        @(posedge i_sys_clk);
        i_irq_ack <= 3'h0;
        rdc("ack clears", 8'h37, 8'h01);
        wr(8'h17, 8'h01, 1'b1);
        rdc("io clear", 8'h37, 8'h00);
        wr(8'h50, 8'h00, 1'b1);
        rdc("io ext ignored", 8'h70, 8'h07);
    endtask : t_flags
    // Up-down mode with top at compare A = 4; normal counting would never overflow here.
    task automatic t_pwm;
        wr(8'hB3, 8'h04);
        wr(8'hB2, 8'h00);
        wr(8'hB0, 8'h01);
        wr(8'hB1, 8'h09);
        cyc(20);
        wr(8'hB1, 8'h08);
        rdc("pwm bottom", 8'h37, 8'h03);
    endtask : t_pwm
    task automatic t_async;
        wr(8'hB6, 8'h40);
        cyc(2);
        `CHK("ext alone buf", 1'b0, o_buf)
        `CHK("ext alone xtal", 1'b0, o_xtal)
        wr(8'hB6, 8'h60);
        cyc(2);
        `CHK("ext buf", 1'b1, o_buf)
        `CHK("xtal off", 1'b0, o_xtal)
        `CHK("sel", 1'b1, o_sel)
        wr(8'hB6, 8'h20);
        cyc(2);
        `CHK("xtal on", 1'b1, o_xtal)
        `CHK("ext off", 1'b0, o_buf)
        wr(8'hB2, 8'h33);
        wr(8'hB3, 8'h90);
        wr(8'hB0, 8'h00);
        wr(8'hB1, 8'h00);
        wr(8'hB4, 8'h5A);
        rdc("busy", 8'hB6, 8'h3F);
        repeat (XC) begin
            @(posedge i_sys_clk);
            i_async_tick <= 1'b1;
            @(posedge i_sys_clk);
            i_async_tick <= 1'b0;
        end
        cyc(2);
        rdc("ready", 8'hB6, 8'h20);
        rdc("cmpb", 8'hB4, 8'h5A);
        rdc("cmpa", 8'hB3, 8'h90);
        rdc("ctrl a", 8'hB0, 8'h00);
        rdc("ctrl b", 8'hB1, 8'h00);
        `CHK("counter", 8'h33, o_counter_value)
        wr(8'hB6, 8'h00);
        cyc(2);
        `CHK("sel off", 1'b0, o_sel)
        wr(8'hB2, 8'h33);
    endtask : t_async
    task automatic t_sync;
        logic seen;
        wr(8'h43, 8'h01);
        seen = o_srst;
        repeat (2) begin
            cyc(1);
            seen |= o_srst;
        end
        `CHK("sync pulse", 1'b1, seen)
        cyc(2);
        `CHK("sync clear", 1'b0, o_srst)
        wr(8'h43, 8'h83);
        wr(8'hB1, 8'h01);
        cyc(10);
        `CHK("held sync", 1'b1, o_srst)
        `CHK("held async", 1'b1, o_arst)
        `CHK("halted", 8'h33, o_counter_value)
        wr(8'h43, 8'h00);
        cyc(3);
        `CHK("released", 2'b00, {o_srst, o_arst})
        `CHK("counting", 8'h36, o_counter_value)
    endtask : t_sync
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // The whole sequence needs about 500 cycles; the limit leaves wide margin.
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        bad_count++;
        $display("BAD watchdog expired");
        print_verdict();
    end
    initial begin
        {i_rst, i_io_space, i_wr, i_rd, i_global_irq_en, i_async_tick} = 6'h20;
        {i_addr, i_wdata, i_irq_ack} = 19'h0;
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_regs();
        t_flags();
        t_pwm();
        t_async();
        t_sync();
        print_verdict();
    end
endmodule : tm2_irq_async_tb
`default_nettype wire
